// ---- sonet_chan_pkg.sv ----
// Constants, types and decoding shared by the channel register bank and its error injector.
package sonet_chan_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int ADDR_W   = 18;
   localparam int DATA_W   = 8;
   localparam int CNT_W    = 8;   // Frame count width.
   localparam int FILL_W   = 8;   // Aligner FIFO fill level width.
   localparam int ES_AW    = 8;   // Elastic store address width.
   localparam int STS_N    = 12;  // STS-1 slots per channel.

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ERR_CTRL_OFS   = 18'h30023;
   localparam logic [ADDR_W-1:0] CONCAT_HI_OFS  = 18'h30024;
   localparam logic [ADDR_W-1:0] CONCAT_LO_OFS  = 18'h30025;
   localparam logic [ADDR_W-1:0] SUMMARY_OFS    = 18'h30026;
   localparam logic [ADDR_W-1:0] SUMMARY_EN_OFS = 18'h30027;
   localparam logic [ADDR_W-1:0] FLAGS_OFS      = 18'h30028;
   localparam logic [ADDR_W-1:0] FLAGS_EN_OFS   = 18'h30029;
   localparam logic [ADDR_W-1:0] AIS_HI_OFS     = 18'h3002A;
   localparam logic [ADDR_W-1:0] AIS_LO_OFS     = 18'h3002B;
   localparam logic [ADDR_W-1:0] AIS_EN_HI_OFS  = 18'h3002C;
   localparam logic [ADDR_W-1:0] AIS_EN_LO_OFS  = 18'h3002D;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int A1A2_CMD_BIT = 0;
   localparam int B1_CMD_BIT   = 1;
   localparam int B1_DIS_BIT   = 2;
   localparam int A1A2_DIS_BIT = 3;
   localparam int SUM_CHAN_BIT = 0;
   localparam int SUM_AIS_BIT  = 1;
   localparam int SUM_ES_BIT   = 2;
   localparam int FIFO_THR_BIT = 0;
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
   localparam logic [ES_AW-1:0]  ES_NEAR   = 8'h01;  // Within one byte.

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      B1_IDLE   = 3'b001,
      B1_PEND   = 3'b010,
      B1_ACTIVE = 3'b100
   } b1_state_type;

   // -----------------------------------------------------------------
   // Per-STS byte packing of a 12-bit STS vector (index is STS number - 1).
   // -----------------------------------------------------------------
   function automatic logic [DATA_W-1:0] sts_hi_byte(input logic [STS_N-1:0] sts);
      sts_hi_byte = {4'h0, sts[11], sts[8], sts[5], sts[2]};
   endfunction

   function automatic logic [DATA_W-1:0] sts_lo_byte(input logic [STS_N-1:0] sts);
      sts_lo_byte = {sts[10], sts[7], sts[4], sts[1], sts[9], sts[6], sts[3], sts[0]};
   endfunction

endpackage

// ---- inject_if.sv ----
// Command and result signals between the register bank and the transmit error injector.
interface inject_if;
   import sonet_chan_pkg::*;
   logic              a1a2_cmd;
   logic              b1_cmd;
   logic [CNT_W-1:0]  frame_count;
   logic [DATA_W-1:0] b1_mask;
   logic              a1a2_corrupt;
   logic [DATA_W-1:0] b1_err_mask;

   modport ctrl (output a1a2_cmd, output b1_cmd, output frame_count, output b1_mask,
                 input a1a2_corrupt, input b1_err_mask);
   modport inj  (input a1a2_cmd, input b1_cmd, input frame_count, input b1_mask,
                 output a1a2_corrupt, output b1_err_mask);
endinterface

// ---- tx_error_injector.sv ----
// Edge-triggered A1/A2 and B1 error injection, aligned to transmit frame starts.
module tx_error_injector
   import sonet_chan_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic frame_start,
   inject_if.inj     bus
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic              a1a2_cmd_q;
      logic              b1_cmd_q;
      logic [CNT_W-1:0]  remain_q;
      logic              corrupt_q;
      b1_state_type      b1_state_q;
      logic [DATA_W-1:0] b1_mask_q;
      logic [DATA_W-1:0] b1_err_q;
   } inj_state_type;

   inj_state_type q;
   inj_state_type d;
   logic          a1a2_rise;
   logic          b1_rise;

   assign a1a2_rise = bus.a1a2_cmd & ~q.a1a2_cmd_q;
   assign b1_rise   = bus.b1_cmd & ~q.b1_cmd_q;

   // Next state; a held command bit never re-arms, only a fresh edge does.
   always_comb begin
      d            = q;
      d.a1a2_cmd_q = bus.a1a2_cmd;
      d.b1_cmd_q   = bus.b1_cmd;
      if (frame_start) begin
         if (q.remain_q != '0) begin
            d.corrupt_q = 1'b1;
            d.remain_q  = q.remain_q - 8'h01;
         end else begin
            d.corrupt_q = 1'b0;
         end
      end
      if (a1a2_rise) begin
         d.remain_q = bus.frame_count;
      end
      case (q.b1_state_q)
         B1_IDLE: begin
            d.b1_err_q = '0;
         end
         B1_PEND: begin
            if (frame_start) begin
               d.b1_state_q = B1_ACTIVE;
               d.b1_err_q   = q.b1_mask_q;
            end
         end
         B1_ACTIVE: begin
            if (frame_start) begin
               d.b1_state_q = B1_IDLE;
               d.b1_err_q   = '0;
            end
         end
         default: begin
            d.b1_state_q = B1_IDLE;
            d.b1_err_q   = '0;
         end
      endcase
      if (b1_rise) begin
         d.b1_state_q = B1_PEND;
         d.b1_mask_q  = bus.b1_mask;
      end
   end

   // Register the whole state.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '{a1a2_cmd_q: 1'b0, b1_cmd_q: 1'b0, remain_q: '0, corrupt_q: 1'b0,
                b1_state_q: B1_IDLE, b1_mask_q: '0, b1_err_q: '0};
      end else begin
         q <= d;
      end
   end

   assign bus.a1a2_corrupt = q.corrupt_q;
   assign bus.b1_err_mask  = q.b1_err_q;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_a1a2_load;
      a1a2_rise |=> (q.remain_q == $past(bus.frame_count));
   endproperty
   a_a1a2_load: assert property (p_a1a2_load) else $error("frame count not loaded on edge");

   property p_a1a2_frame;
      (frame_start && !a1a2_rise && q.remain_q != '0) |=>
         (q.corrupt_q && q.remain_q == $past(q.remain_q) - 8'h01);
   endproperty
   a_a1a2_frame: assert property (p_a1a2_frame) else $error("framing not corrupted");

   property p_single_shot;
      (bus.a1a2_cmd && q.a1a2_cmd_q && !frame_start) |=> (q.remain_q == $past(q.remain_q));
   endproperty
   a_single_shot: assert property (p_single_shot) else $error("held command re-armed");

   property p_b1_mask;
      (q.b1_state_q == B1_PEND && frame_start && !b1_rise) |=>
         (bus.b1_err_mask == $past(q.b1_mask_q)) ##1 ($past(frame_start) || bus.b1_err_mask == $past(q.b1_mask_q));
   endproperty
   a_b1_mask: assert property (p_b1_mask) else $error("B1 mask not applied");

   c_a1a2_run: cover property (a1a2_rise ##[1:50] q.corrupt_q);
   c_b1_run:   cover property (b1_rise ##[1:50] (bus.b1_err_mask != '0));

endmodule

// ---- sonet_channel_error_alarm_regs.sv ----
// Per-channel error insertion control, concatenation, alarm and summary register bank.
//
// Strobed register access is this design's own decision.
module sonet_channel_error_alarm_regs
   import sonet_chan_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              frame_start,
   input  wire logic [CNT_W-1:0]  frame_count,
   input  wire logic [DATA_W-1:0] b1_mask,
   output logic                   a1a2_corrupt,
   output logic      [DATA_W-1:0] b1_err_mask,
   output logic                   a1a2_insert_en,
   output logic                   b1_insert_en,
   input  wire logic [STS_N-1:0]  concat_sts,
   input  wire logic [STS_N-1:0]  ais_sts,
   input  wire logic [ES_AW-1:0]  es_wr_addr,
   input  wire logic [ES_AW-1:0]  es_rd_addr,
   input  wire logic [FILL_W-1:0] fifo_fill,
   input  wire logic [FILL_W-1:0] fifo_min,
   input  wire logic [FILL_W-1:0] fifo_max,
   input  wire logic [5:0]        chan_alarm_evt,
   output logic      [2:0]        global_alarm
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [3:0]        ctrl_q;
      logic [2:0]        sum_en_q;
      logic [6:0]        flags_q;
      logic [6:0]        flags_en_q;
      logic [3:0]        ais_en_hi_q;
      logic [7:0]        ais_en_lo_q;
      logic [3:0]        concat_hi_q;
      logic [7:0]        concat_lo_q;
      logic [3:0]        ais_hi_q;
      logic [7:0]        ais_lo_q;
      logic [2:0]        summary_q;
      logic [2:0]        global_q;
      logic [DATA_W-1:0] rdata_q;
   } regs_state_type;

   regs_state_type q;
   regs_state_type d;
   logic           thr_viol;
   logic           es_near;
   logic [ES_AW-1:0] es_diff;
   logic [6:0]     flag_set;
   logic [DATA_W-1:0] concat_hi_b;
   logic [DATA_W-1:0] concat_lo_b;
   logic [DATA_W-1:0] ais_hi_b;
   logic [DATA_W-1:0] ais_lo_b;

   inject_if inj_bus ();

   // -----------------------------------------------------------------
   // Event detection
   // -----------------------------------------------------------------

   assign thr_viol = (fifo_fill < fifo_min) || (fifo_fill > fifo_max);

   assign es_diff = es_wr_addr - es_rd_addr;
   assign es_near = (es_diff == 8'h00)
                 || (es_diff == ES_NEAR)
                 || (es_diff == 8'h00 - ES_NEAR);

   // Hardware set sources for the channel alarm flags; bit 0 is the threshold check.
   assign flag_set = {chan_alarm_evt, thr_viol};

   // Per-STS packing of the indication inputs into register layout.
   assign concat_hi_b = sts_hi_byte(concat_sts);
   assign concat_lo_b = sts_lo_byte(concat_sts);
   assign ais_hi_b    = sts_hi_byte(ais_sts);
   assign ais_lo_b    = sts_lo_byte(ais_sts);

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   // Writes to read-only or unmapped offsets are ignored. Software is trusted to clear a
   // command bit before setting it again, since the injector reacts only to rising edges.
   always_comb begin
      d = q;

      // Register writes.
      if (reg_wr) begin
         case (reg_addr)
            ERR_CTRL_OFS:   d.ctrl_q      = reg_wdata[3:0];
            SUMMARY_EN_OFS: d.sum_en_q    = reg_wdata[2:0];
            FLAGS_EN_OFS:   d.flags_en_q  = reg_wdata[6:0];
            AIS_EN_HI_OFS:  d.ais_en_hi_q = reg_wdata[3:0];
            AIS_EN_LO_OFS:  d.ais_en_lo_q = reg_wdata;
            FLAGS_OFS:      d.flags_q     = q.flags_q & ~reg_wdata[6:0];
            default: begin
               d.ctrl_q = q.ctrl_q;
            end
         endcase
      end

      // sticky set, wins over a clear in the same cycle
      d.flags_q = d.flags_q | flag_set;

      d.concat_hi_q = concat_hi_b[3:0];
      d.concat_lo_q = concat_lo_b;
      d.ais_hi_q    = ais_hi_b[3:0];
      d.ais_lo_q    = ais_lo_b;

      d.summary_q[SUM_CHAN_BIT] = |(q.flags_q & q.flags_en_q);
      d.summary_q[SUM_AIS_BIT]  = (|(q.ais_hi_q & q.ais_en_hi_q)) | (|(q.ais_lo_q & q.ais_en_lo_q));
      d.summary_q[SUM_ES_BIT]   = es_near;

      d.global_q = q.summary_q & q.sum_en_q;

      // read data, zero outside a read and for unmapped offsets
      d.rdata_q = REG_RESET;
      if (reg_rd) begin
         case (reg_addr)
            ERR_CTRL_OFS:   d.rdata_q = {4'h0, q.ctrl_q};
            CONCAT_HI_OFS:  d.rdata_q = {4'h0, q.concat_hi_q};
            CONCAT_LO_OFS:  d.rdata_q = q.concat_lo_q;
            SUMMARY_OFS:    d.rdata_q = {5'h00, q.summary_q};
            SUMMARY_EN_OFS: d.rdata_q = {5'h00, q.sum_en_q};
            FLAGS_OFS:      d.rdata_q = {1'b0, q.flags_q};
            FLAGS_EN_OFS:   d.rdata_q = {1'b0, q.flags_en_q};
            AIS_HI_OFS:     d.rdata_q = {4'h0, q.ais_hi_q};
            AIS_LO_OFS:     d.rdata_q = q.ais_lo_q;
            AIS_EN_HI_OFS:  d.rdata_q = {4'h0, q.ais_en_hi_q};
            AIS_EN_LO_OFS:  d.rdata_q = q.ais_en_lo_q;
            default: begin
               d.rdata_q = REG_RESET;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   // everything clears to zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // -----------------------------------------------------------------
   // Transmit injection and insertion control
   // -----------------------------------------------------------------
   assign inj_bus.a1a2_cmd    = q.ctrl_q[A1A2_CMD_BIT];
   assign inj_bus.b1_cmd      = q.ctrl_q[B1_CMD_BIT];
   assign inj_bus.frame_count = frame_count;
   assign inj_bus.b1_mask     = b1_mask;

   tx_error_injector u_injector (
      .clk         (clk),
      .rst         (rst),
      .frame_start (frame_start),
      .bus         (inj_bus.inj)
   );

   assign a1a2_corrupt = inj_bus.a1a2_corrupt;
   assign b1_err_mask  = inj_bus.b1_err_mask;

   assign b1_insert_en   = ~q.ctrl_q[B1_DIS_BIT];
   assign a1a2_insert_en = ~q.ctrl_q[A1A2_DIS_BIT];

   assign global_alarm = q.global_q;
   assign reg_rdata    = q.rdata_q;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_flag_set;
      thr_viol |=> q.flags_q[FIFO_THR_BIT] ##1 (q.flags_q[FIFO_THR_BIT] || $past(reg_wr));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("threshold flag not set");

   property p_flag_w1c;
      (reg_wr && reg_addr == FLAGS_OFS && reg_wdata[FIFO_THR_BIT] && !thr_viol) |=>
         !q.flags_q[FIFO_THR_BIT];
   endproperty
   a_flag_w1c: assert property (p_flag_w1c) else $error("threshold flag not cleared");

   property p_flag_sticky;
      (q.flags_q[FIFO_THR_BIT] && !(reg_wr && reg_addr == FLAGS_OFS)) |=> q.flags_q[FIFO_THR_BIT];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("threshold flag dropped");

   property p_chan_summary;
      (thr_viol && q.flags_en_q[FIFO_THR_BIT] && !reg_wr) |=> ##1 q.summary_q[SUM_CHAN_BIT];
   endproperty
   a_chan_summary: assert property (p_chan_summary) else $error("channel summary missing");

   property p_ais_summary;
      (q.ais_hi_q[0] && q.ais_en_hi_q[0]) |=> q.summary_q[SUM_AIS_BIT];
   endproperty
   a_ais_summary: assert property (p_ais_summary) else $error("AIS summary missing");

   property p_es_summary;
      (es_wr_addr == es_rd_addr) |=> q.summary_q[SUM_ES_BIT];
   endproperty
   a_es_summary: assert property (p_es_summary) else $error("elastic store summary missing");

   property p_global_gate;
      !q.sum_en_q[SUM_AIS_BIT] |=> !global_alarm[SUM_AIS_BIT];
   endproperty
   a_global_gate: assert property (p_global_gate) else $error("disabled summary propagated");

   property p_concat_read;
      (reg_rd && reg_addr == CONCAT_LO_OFS) |=> (reg_rdata == sts_lo_byte($past(concat_sts, 2)));
   endproperty
   a_concat_read: assert property (p_concat_read) else $error("concat readback wrong");

   property p_b1_dis;
      (reg_wr && reg_addr == ERR_CTRL_OFS) |=> (b1_insert_en == !$past(reg_wdata[B1_DIS_BIT]));
   endproperty
   a_b1_dis: assert property (p_b1_dis) else $error("B1 insert enable wrong");

   property p_idle_read;
      !reg_rd |=> (reg_rdata == REG_RESET);
   endproperty
   a_idle_read: assert property (p_idle_read) else $error("read data outside read cycle");

   // Framing insert enable follows its disable bit one cycle after the write.
   property p_a1a2_dis;
      (reg_wr && reg_addr == ERR_CTRL_OFS) |=>
         (a1a2_insert_en == !$past(reg_wdata[A1A2_DIS_BIT]));
   endproperty
   a_a1a2_dis: assert property (p_a1a2_dis) else $error("A1/A2 insert enable wrong");

   // Unused and unmapped bits read zero, so software never sees stale noise.
   property p_ctrl_unused;
      (reg_rd && reg_addr == ERR_CTRL_OFS) |=>
         (reg_rdata[7:4] == 4'h0);
   endproperty
   a_ctrl_unused: assert property (p_ctrl_unused) else $error("control high bits set");

   property p_sum_unused;
      (reg_rd && reg_addr == SUMMARY_OFS) |=>
         (reg_rdata[7:3] == 5'h00);
   endproperty
   a_sum_unused: assert property (p_sum_unused) else $error("summary high bits set");

   property p_unmapped;
      (reg_rd && reg_addr > AIS_EN_LO_OFS) |=>
         (reg_rdata == REG_RESET);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   // A zero write keeps the flag, and a clear loses to a fresh violation.
   property p_flag_keep;
      (reg_wr && reg_addr == FLAGS_OFS && !reg_wdata[FIFO_THR_BIT] && q.flags_q[FIFO_THR_BIT]) |=>
         q.flags_q[FIFO_THR_BIT];
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("zero write cleared flag");

   property p_set_wins;
      (reg_wr && reg_addr == FLAGS_OFS && thr_viol) |=>
         q.flags_q[FIFO_THR_BIT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat new violation");

   // Enable gating into the summary bits.
   property p_flag_gate;
      (q.flags_en_q == 7'h00) |=>
         !q.summary_q[SUM_CHAN_BIT];
   endproperty
   a_flag_gate: assert property (p_flag_gate) else $error("disabled flag in summary");

   property p_evt_summary;
      (q.flags_q[3] && q.flags_en_q[3]) |=>
         q.summary_q[SUM_CHAN_BIT];
   endproperty
   a_evt_summary: assert property (p_evt_summary) else $error("enabled flag not summarised");

   property p_ais_gate;
      (q.ais_en_hi_q == 4'h0 && q.ais_en_lo_q == 8'h00) |=>
         !q.summary_q[SUM_AIS_BIT];
   endproperty
   a_ais_gate: assert property (p_ais_gate) else $error("disabled AIS in summary");

   // Elastic store distance: one apart is near, two apart is not.
   property p_es_near;
      (es_rd_addr == es_wr_addr + 8'h01) |=>
         q.summary_q[SUM_ES_BIT];
   endproperty
   a_es_near: assert property (p_es_near) else $error("near addresses not flagged");

   property p_es_far;
      (es_rd_addr == es_wr_addr + 8'h02) |=>
         !q.summary_q[SUM_ES_BIT];
   endproperty
   a_es_far: assert property (p_es_far) else $error("far addresses flagged");

   // Propagation to the global alarm.
   property p_global_set;
      (q.summary_q[SUM_CHAN_BIT] && q.sum_en_q[SUM_CHAN_BIT]) |=>
         global_alarm[SUM_CHAN_BIT];
   endproperty
   a_global_set: assert property (p_global_set) else $error("enabled summary not propagated");

   property p_es_gate;
      !q.sum_en_q[SUM_ES_BIT] |=>
         !global_alarm[SUM_ES_BIT];
   endproperty
   a_es_gate: assert property (p_es_gate) else $error("disabled store alarm propagated");

   c_w1c_race:  cover property (reg_wr && reg_addr == FLAGS_OFS && reg_wdata[0] && thr_viol);
   c_global:    cover property (global_alarm != 3'h0);
   c_concat_rd: cover property (reg_rd && reg_addr == CONCAT_HI_OFS ##1 reg_rdata != 8'h00);

endmodule

// ---- sonet_channel_error_alarm_regs_tb.sv ----
// Self-checking register and injection testbench for the channel error and alarm register bank.
module sonet_channel_error_alarm_regs_tb;
   import sonet_chan_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // -----------------------------------------------------------------
   // Signals, counters and the comparison macro
   // -----------------------------------------------------------------
   logic              clk;
   logic              rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic              frame_start;
   logic [CNT_W-1:0]  frame_count;
   logic [DATA_W-1:0] b1_mask;
   logic              a1a2_corrupt;
   logic [DATA_W-1:0] b1_err_mask;
   logic              a1a2_insert_en;
   logic              b1_insert_en;
   logic [STS_N-1:0]  concat_sts;
   logic [STS_N-1:0]  ais_sts;
   logic [ES_AW-1:0]  es_wr_addr;
   logic [ES_AW-1:0]  es_rd_addr;
   logic [FILL_W-1:0] fifo_fill;
   logic [FILL_W-1:0] fifo_min;
   logic [FILL_W-1:0] fifo_max;
   logic [5:0]        chan_alarm_evt;
   logic [2:0]        global_alarm;
   int                miscompares;
   int                cmp_count;
   logic [15:0]       sts_exp;

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end

   sonet_channel_error_alarm_regs i_dut (
      .clk            (clk),
      .rst            (rst),
      .reg_addr       (reg_addr),
      .reg_wdata      (reg_wdata),
      .reg_wr         (reg_wr),
      .reg_rd         (reg_rd),
      .reg_rdata      (reg_rdata),
      .frame_start    (frame_start),
      .frame_count    (frame_count),
      .b1_mask        (b1_mask),
      .a1a2_corrupt   (a1a2_corrupt),
      .b1_err_mask    (b1_err_mask),
      .a1a2_insert_en (a1a2_insert_en),
      .b1_insert_en   (b1_insert_en),
      .concat_sts     (concat_sts),
      .ais_sts        (ais_sts),
      .es_wr_addr     (es_wr_addr),
      .es_rd_addr     (es_rd_addr),
      .fifo_fill      (fifo_fill),
      .fifo_min       (fifo_min),
      .fifo_max       (fifo_max),
      .chan_alarm_evt (chan_alarm_evt),
      .global_alarm   (global_alarm)
   );

   // -----------------------------------------------------------------
   // Clock, bus tasks and helpers
   // -----------------------------------------------------------------
   // The 5 ns period gives the 200 MHz core clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // A write is a single strobe cycle; the strobe drops at the next edge.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // Read data are only valid in the cycle after the strobe, so sample just after that edge.
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      `CHK(reg_rdata, exp)
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One frame: a single-cycle start pulse, then time for the registered outputs to settle.
   task automatic frame();
      @(posedge clk);
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      #1;
   endtask

   // Expected packing of the concatenation bytes, written out independently of the design.
   function automatic logic [15:0] pack_sts(input logic [STS_N-1:0] s);
      pack_sts = {4'h0, s[11], s[8], s[5], s[2], s[10], s[7], s[4], s[1], s[9], s[6], s[3], s[0]};
   endfunction

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Watchdog
   // -----------------------------------------------------------------
   // The tests need well under a thousand cycles; five thousand means a hang.
   initial begin
      #(5000 * 5);
      miscompares++;
      finish_test();
   end

   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial begin
      rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
      frame_start = 1'b0; frame_count = 8'h02; b1_mask = 8'hA5;
      concat_sts = 12'h000; ais_sts = 12'h000; es_wr_addr = 8'h80; es_rd_addr = 8'h00;
      fifo_fill = 8'h80; fifo_min = 8'h10; fifo_max = 8'hF0; chan_alarm_evt = 6'h00;
      miscompares = 0; cmp_count = 0;
      idle(3);
      rst <= 1'b0;
      idle(2);
      for (int a = 'h30023; a <= 'h3002D; a++) rd(a[ADDR_W-1:0], 8'h00);
      `CHK({a1a2_insert_en, b1_insert_en, a1a2_corrupt, global_alarm}, 6'b110000)
      rd(18'h30030, 8'h00);
      $display("test reset done");

      // Control register: unused bits read zero, disables drive the insert enables.
      wr(ERR_CTRL_OFS, 8'hFC);
      rd(ERR_CTRL_OFS, 8'h0C);
      `CHK({a1a2_insert_en, b1_insert_en}, 2'b00)
      wr(ERR_CTRL_OFS, 8'h04);
      idle(1);
      `CHK({a1a2_insert_en, b1_insert_en}, 2'b10)
      wr(ERR_CTRL_OFS, 8'h00);
      wr(CONCAT_LO_OFS, 8'hFF);
      $display("test control done");

      // Concatenation indications, read-only.
      concat_sts <= 12'h96C;
      sts_exp = pack_sts(12'h96C);
      idle(2);
      rd(CONCAT_HI_OFS, sts_exp[15:8]);
      rd(CONCAT_LO_OFS, sts_exp[7:0]);
      $display("test concat done");

      // Channel flags, enables, summary and global alarm.
      @(posedge clk) chan_alarm_evt <= 6'b000100;
      @(posedge clk) chan_alarm_evt <= 6'b000000;
      idle(3);
      rd(FLAGS_OFS, 8'h08);
      rd(SUMMARY_OFS, 8'h00);
      wr(FLAGS_EN_OFS, 8'h77);
      idle(3);
      rd(SUMMARY_OFS, 8'h00);
      wr(FLAGS_EN_OFS, 8'h09);
      idle(3);
      rd(SUMMARY_OFS, 8'h01);
      `CHK(global_alarm, 3'b000)
      wr(SUMMARY_EN_OFS, 8'h01);
      idle(3);
      `CHK(global_alarm, 3'b001)
      wr(FLAGS_OFS, 8'h08);
      idle(3);
      rd(FLAGS_OFS, 8'h00);
      rd(SUMMARY_OFS, 8'h00);
      $display("test channel alarm done");

      // FIFO threshold flag is sticky until a one is written to it.
      // Out-of-sync rises with the violation here; the next violation finds the threshold flag already set, and the FE write then clears only out-of-sync.
      @(posedge clk);
      fifo_fill      <= 8'hF1;
      chan_alarm_evt <= 6'h20;
      @(posedge clk);
      fifo_fill      <= 8'h80;
      chan_alarm_evt <= 6'h00;
      idle(2);
      rd(FLAGS_OFS, 8'h41);
      @(posedge clk) fifo_fill <= 8'h0F;
      @(posedge clk) fifo_fill <= 8'h80;
      wr(FLAGS_OFS, 8'hFE);
      idle(2);
      rd(FLAGS_OFS, 8'h01);
      wr(FLAGS_OFS, 8'h01);
      idle(2);
      rd(FLAGS_OFS, 8'h00);
      $display("test fifo threshold done");

      // AIS-P and elastic store summaries, gated into the global alarm.
      ais_sts <= 12'h004;
      es_wr_addr <= 8'h05;
      es_rd_addr <= 8'h06;
      idle(3);
      rd(AIS_HI_OFS, 8'h01);
      rd(SUMMARY_OFS, 8'h04);
      wr(AIS_EN_HI_OFS, 8'h01);
      wr(SUMMARY_EN_OFS, 8'h06);
      idle(3);
      rd(SUMMARY_OFS, 8'h06);
      `CHK(global_alarm, 3'b110)
      wr(SUMMARY_EN_OFS, 8'h02);
      es_rd_addr <= 8'h07;
      idle(3);
      `CHK(global_alarm, 3'b010)
      rd(SUMMARY_OFS, 8'h02);
      $display("test summary done");

      // A1/A2 injection runs for the frame count; a held command does not fire again.
      wr(ERR_CTRL_OFS, 8'h01);
      idle(3);
      `CHK(a1a2_corrupt, 1'b0)
      frame();
      `CHK(a1a2_corrupt, 1'b1)
      frame();
      `CHK(a1a2_corrupt, 1'b1)
      frame();
      `CHK(a1a2_corrupt, 1'b0)
      wr(ERR_CTRL_OFS, 8'h01);
      frame();
      `CHK(a1a2_corrupt, 1'b0)
      // Clearing the framing command and raising the parity one in one write.
      wr(ERR_CTRL_OFS, 8'h02);
      frame();
      `CHK({a1a2_corrupt, b1_err_mask}, 9'h0A5)
      frame();
      `CHK(b1_err_mask, 8'h00)
      $display("test injection done");
      finish_test();
   end

endmodule
